// [xb_consts.vh]
// named constants for the crossbar hub: address map, target codes,
// owner codes and peripheral clock divider.
// assumes a 32-bit byte address space seen by every master.
`ifndef XB_CONSTS_VH
`define XB_CONSTS_VH

// ----------------------------------------------------------------
// address map (top nibble picks the region)
// ----------------------------------------------------------------
`define XB_NIB_ROM 4'h0
`define XB_NIB_RAM 4'h1
`define XB_NIB_PER 4'h4
`define XB_ROM_BYTES 28'h0060000
`define XB_RAM_BYTES 28'h0040000
`define XB_RAM_AW 15
`define XB_RAM_TOP 32767

// ----------------------------------------------------------------
// target and owner codes
// ----------------------------------------------------------------
`define XB_T_NONE 2'h0
`define XB_T_MEM 2'h1
`define XB_T_PER 2'h2
`define XB_O_ACC0 2'h0
`define XB_O_ACC1 2'h1
`define XB_O_CPU 2'h2

// ----------------------------------------------------------------
// peripheral clock: sys_clk divided by this count
// ----------------------------------------------------------------
`define XB_PER_DIV 2'h2
`define XB_PER_HALF 2'h1

`endif

// [xb_crossbar.v]
// crossbar hub: fixed-priority arbitration of cpu, accelerator and
// host port masters onto the unified memory and the peripheral bus.
// assumes masters hold a request stable until its one-cycle ack.
`timescale 1ns/1ps
`include "xb_consts.vh"

// Operation
// - contention: accelerator before host on the shared port, accelerator before core on peripherals
// - masters on different targets run in the same cycle
// - only some paths exist; host port never reaches peripherals
// - memory serves three of four sources: two cpu, fetch, shared port
// - core data accesses to memory answer in one cycle
// - the 32-bit shared memory port serves accelerator or host, one at a time
// - host may be confined to a 64 Kbyte page; only core moves it
// - two accelerator channels run together on different targets
// - ram and rom form one program and data space, no split
// - core and memory on core clock; peripherals on peripheral clock
module xb_crossbar (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // core data port a (memory and peripherals)
   input wire ca_req,
   input wire ca_we,
   input wire [31:0] ca_addr,
   input wire [63:0] ca_wdata,
   output reg ca_ack,
   output reg ca_err,
   output reg [63:0] ca_rdata,
   // core data port b (memory only)
   input wire cb_req,
   input wire cb_we,
   input wire [31:0] cb_addr,
   input wire [63:0] cb_wdata,
   output reg cb_ack,
   output reg cb_err,
   output reg [63:0] cb_rdata,
   // program fetch
   input wire pf_req,
   input wire [31:0] pf_addr,
   output reg pf_ack,
   output reg [255:0] pf_rdata,
   // data movement accelerator, channel 0
   input wire acc0_req,
   input wire acc0_we,
   input wire [31:0] acc0_addr,
   input wire [31:0] acc0_wdata,
   output reg acc0_ack,
   output reg acc0_err,
   output reg [31:0] acc0_rdata,
   // data movement accelerator, channel 1
   input wire acc1_req,
   input wire acc1_we,
   input wire [31:0] acc1_addr,
   input wire [31:0] acc1_wdata,
   output reg acc1_ack,
   output reg acc1_err,
   output reg [31:0] acc1_rdata,
   // host port
   input wire host_req,
   input wire host_we,
   input wire [31:0] host_addr,
   input wire [31:0] host_wdata,
   output reg host_ack,
   output reg host_err,
   output reg [31:0] host_rdata,
   // host page control, driven by the core only
   input wire cpu_page_wr,
   input wire cpu_page_en,
   input wire [15:0] cpu_page_base,
   // peripheral target bus
   output reg per_req,
   output reg per_we,
   output reg [31:0] per_addr,
   output reg [31:0] per_wdata,
   input wire per_ack,
   input wire [31:0] per_rdata,
   output reg peripheral_clock
);

   localparam PS_IDLE = 2'h0;
   localparam PS_LAUNCH = 2'h1;
   localparam PS_WAIT = 2'h2;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [1:0] xb_decode;
      input [31:0] a;
      begin
         if (a[31:28] == `XB_NIB_PER)
            xb_decode = `XB_T_PER;
         else if (a[31:28] == `XB_NIB_RAM && a[27:0] < `XB_RAM_BYTES)
            xb_decode = `XB_T_MEM;
         else if (a[31:28] == `XB_NIB_ROM && a[27:0] < `XB_ROM_BYTES)
            xb_decode = `XB_T_MEM;
         else
            xb_decode = `XB_T_NONE;
      end
   endfunction

   function xb_is_ram;
      input [31:0] a;
      begin
         xb_is_ram = (a[31:28] == `XB_NIB_RAM);
      end
   endfunction

   function [31:0] xb_half;
      input [63:0] w;
      input hi;
      begin
         xb_half = hi ? w[63:32] : w[31:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg [1:0] rst_sync;
   wire rst_n = rst_sync[1];

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'h1};
   end

   // ----------------------------------------------------------------
   // host page window
   // ----------------------------------------------------------------
   reg page_en;
   reg [15:0] page_base;
   // only the core port can move the window
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_en <= 1'h0;
         page_base <= 16'h0000;
      end else if (cpu_page_wr) begin
         page_en <= cpu_page_en;
         page_base <= cpu_page_base;
      end
   end
   wire [31:0] host_eaddr = page_en ? {page_base, host_addr[15:0]} : host_addr;

   // ----------------------------------------------------------------
   // peripheral clock divider
   // ----------------------------------------------------------------
   // per_req only moves on ticks of the slower clock; its address and data fields load on any cycle
   reg [1:0] per_cnt;
   wire per_tick = (per_cnt == `XB_PER_DIV - 2'h1);
   wire [1:0] next_per_cnt = per_tick ? 2'h0 : per_cnt + 2'h1;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         per_cnt <= 2'h0;
         peripheral_clock <= 1'h0;
      end else begin
         per_cnt <= next_per_cnt;
         // looks one count ahead so the pin stands high in the tick cycle itself
         peripheral_clock <= (next_per_cnt == `XB_PER_DIV - 2'h1);
      end
   end

   // ----------------------------------------------------------------
   // request qualification
   // ----------------------------------------------------------------
   reg [1:0] pst;
   reg [1:0] owner;
   wire per_busy = (pst != PS_IDLE);
   wire per_done = (pst == PS_WAIT) & per_tick & per_ack;

   wire [1:0] ca_tgt = xb_decode(ca_addr);
   wire [1:0] cb_tgt = xb_decode(cb_addr);
   wire [1:0] pf_tgt = xb_decode(pf_addr);
   wire [1:0] a0_tgt = xb_decode(acc0_addr);
   wire [1:0] a1_tgt = xb_decode(acc1_addr);
   wire [1:0] h_tgt = xb_decode(host_eaddr);

   // a request already acked or already owning the peripheral is not new
   wire ca_new = ca_req & ~ca_ack & ~(per_busy & owner == `XB_O_CPU);
   wire cb_new = cb_req & ~cb_ack;
   wire pf_new = pf_req & ~pf_ack;
   wire a0_new = acc0_req & ~acc0_ack & ~(per_busy & owner == `XB_O_ACC0);
   wire a1_new = acc1_req & ~acc1_ack & ~(per_busy & owner == `XB_O_ACC1);
   wire h_new = host_req & ~host_ack;

   // missing paths answer with an error
   wire ca_bad = ca_new & (ca_tgt == `XB_T_NONE);
   wire cb_bad = cb_new & (cb_tgt != `XB_T_MEM);
   wire a0_bad = a0_new & (a0_tgt == `XB_T_NONE);
   wire a1_bad = a1_new & (a1_tgt == `XB_T_NONE);
   wire h_bad = h_new & (h_tgt != `XB_T_MEM);

   // ----------------------------------------------------------------
   // memory controller arbitration
   // ----------------------------------------------------------------
   // core ports are never refused so they finish in one cycle
   wire ca_mem = ca_new & (ca_tgt == `XB_T_MEM);
   wire cb_mem = cb_new & (cb_tgt == `XB_T_MEM);
   // shared port: accelerator channels before host, one winner
   wire a0_pss = a0_new & (a0_tgt == `XB_T_MEM);
   wire a1_pss = a1_new & (a1_tgt == `XB_T_MEM) & ~a0_pss;
   wire h_pss = h_new & (h_tgt == `XB_T_MEM) & ~a0_pss & ~(a1_new & a1_tgt == `XB_T_MEM);
   wire pss_any = a0_pss | a1_pss | h_pss;
   // at most three of the four sources per cycle; fetch yields
   wire pf_take = pf_new & ~(ca_mem & cb_mem & pss_any);

   reg [31:0] pss_addr;
   reg [31:0] pss_wdata;
   reg pss_we;
   always @* begin
      pss_addr = host_eaddr;
      pss_wdata = host_wdata;
      pss_we = host_we;
      if (a0_pss) begin
         pss_addr = acc0_addr;
         pss_wdata = acc0_wdata;
         pss_we = acc0_we;
      end else if (a1_pss) begin
         pss_addr = acc1_addr;
         pss_wdata = acc1_wdata;
         pss_we = acc1_we;
      end
   end

   // ----------------------------------------------------------------
   // unified ram array
   // ----------------------------------------------------------------
   // one flat space for code and data; rom area reads zero here since
   // its image lives outside this block
   reg [63:0] ram [0:`XB_RAM_TOP];
   wire [`XB_RAM_AW-1:0] ca_idx = ca_addr[`XB_RAM_AW+2:3];
   wire [`XB_RAM_AW-1:0] cb_idx = cb_addr[`XB_RAM_AW+2:3];
   wire [`XB_RAM_AW-1:0] ps_idx = pss_addr[`XB_RAM_AW+2:3];
   wire [`XB_RAM_AW-3:0] pf_row = pf_addr[`XB_RAM_AW+2:5];
   wire [63:0] ca_word = xb_is_ram(ca_addr) ? ram[ca_idx] : 64'h0;
   wire [63:0] cb_word = xb_is_ram(cb_addr) ? ram[cb_idx] : 64'h0;
   wire [31:0] ps_word = xb_is_ram(pss_addr) ? xb_half(ram[ps_idx], pss_addr[2]) : 32'h0;
   wire [255:0] pf_line = (xb_is_ram(pf_addr) && pf_tgt == `XB_T_MEM) ?
      {ram[{pf_row, 2'h3}], ram[{pf_row, 2'h2}], ram[{pf_row, 2'h1}], ram[{pf_row, 2'h0}]} : 256'h0;

   // same-word writes in one cycle: shared port lands last and wins its 32-bit half
   always @(posedge sys_clk) begin
      if (ca_mem & ca_we & xb_is_ram(ca_addr))
         ram[ca_idx] <= ca_wdata;
      if (cb_mem & cb_we & xb_is_ram(cb_addr))
         ram[cb_idx] <= cb_wdata;
      if (pss_any & pss_we & xb_is_ram(pss_addr)) begin
         if (pss_addr[2])
            ram[ps_idx][63:32] <= pss_wdata;
         else
            ram[ps_idx][31:0] <= pss_wdata;
      end
   end

   // ----------------------------------------------------------------
   // peripheral target arbitration
   // ----------------------------------------------------------------
   // accelerator channels before the core; host has no path here
   wire a0_per = a0_new & (a0_tgt == `XB_T_PER);
   wire a1_per = a1_new & (a1_tgt == `XB_T_PER);
   wire ca_per = ca_new & (ca_tgt == `XB_T_PER);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pst <= PS_IDLE;
         owner <= `XB_O_ACC0;
         per_req <= 1'h0;
         per_we <= 1'h0;
         per_addr <= 32'h0;
         per_wdata <= 32'h0;
      end else begin
         case (pst)
            PS_IDLE: begin
               if (a0_per) begin
                  owner <= `XB_O_ACC0;
                  per_we <= acc0_we;
                  per_addr <= acc0_addr;
                  per_wdata <= acc0_wdata;
                  pst <= PS_LAUNCH;
               end else if (a1_per) begin
                  owner <= `XB_O_ACC1;
                  per_we <= acc1_we;
                  per_addr <= acc1_addr;
                  per_wdata <= acc1_wdata;
                  pst <= PS_LAUNCH;
               end else if (ca_per) begin
                  owner <= `XB_O_CPU;
                  per_we <= ca_we;
                  per_addr <= ca_addr;
                  per_wdata <= ca_wdata[31:0];
                  pst <= PS_LAUNCH;
               end
            end
            PS_LAUNCH: begin
               if (per_tick) begin
                  per_req <= 1'h1;
                  pst <= PS_WAIT;
               end
            end
            PS_WAIT: begin
               // grant held until the target acks
               if (per_done) begin
                  per_req <= 1'h0;
                  pst <= PS_IDLE;
               end
            end
            default: begin
               per_req <= 1'h0;
               pst <= PS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // answers to the masters
   // ----------------------------------------------------------------
   // memory and peripheral answers run side by side
   wire dn_ca = per_done & (owner == `XB_O_CPU);
   wire dn_a0 = per_done & (owner == `XB_O_ACC0);
   wire dn_a1 = per_done & (owner == `XB_O_ACC1);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ca_ack <= 1'h0;
         ca_err <= 1'h0;
         ca_rdata <= 64'h0;
         cb_ack <= 1'h0;
         cb_err <= 1'h0;
         cb_rdata <= 64'h0;
         pf_ack <= 1'h0;
         pf_rdata <= 256'h0;
         acc0_ack <= 1'h0;
         acc0_err <= 1'h0;
         acc0_rdata <= 32'h0;
         acc1_ack <= 1'h0;
         acc1_err <= 1'h0;
         acc1_rdata <= 32'h0;
         host_ack <= 1'h0;
         host_err <= 1'h0;
         host_rdata <= 32'h0;
      end else begin
         ca_ack <= ca_mem | ca_bad | dn_ca;
         ca_err <= ca_bad;
         cb_ack <= cb_mem | cb_bad;
         cb_err <= cb_bad;
         pf_ack <= pf_take;
         acc0_ack <= a0_pss | a0_bad | dn_a0;
         acc0_err <= a0_bad;
         acc1_ack <= a1_pss | a1_bad | dn_a1;
         acc1_err <= a1_bad;
         host_ack <= h_pss | h_bad;
         host_err <= h_bad;
         if (ca_mem)
            ca_rdata <= ca_word;
         else if (dn_ca)
            ca_rdata <= {32'h0, per_rdata};
         if (cb_mem)
            cb_rdata <= cb_word;
         if (pf_take)
            pf_rdata <= pf_line;
         if (a0_pss)
            acc0_rdata <= ps_word;
         else if (dn_a0)
            acc0_rdata <= per_rdata;
         if (a1_pss)
            acc1_rdata <= ps_word;
         else if (dn_a1)
            acc1_rdata <= per_rdata;
         if (h_pss)
            host_rdata <= ps_word;
      end
   end

endmodule

// [xb_crossbar_monitor.sv]
// checker for the crossbar hub: arbitration order, answer timing, peripheral bus.
// assumes it is bound to xb_crossbar and sees only that module's ports.
`timescale 1ns/1ps
module xb_crossbar_monitor (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // masters
   input wire cb_req,
   input wire cb_ack,
   input wire pf_req,
   input wire pf_ack,
   input wire acc0_req,
   input wire [31:0] acc0_addr,
   input wire acc0_ack,
   input wire acc0_err,
   input wire acc1_req,
   input wire [31:0] acc1_addr,
   input wire acc1_ack,
   input wire host_req,
   input wire [31:0] host_addr,
   input wire host_ack,
   input wire host_err,
   input wire cpu_page_wr,
   input wire cpu_page_en,
   // peripheral bus
   input wire per_req,
   input wire per_ack,
   input wire peripheral_clock
);
   default clocking mon_clk @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // page window tracked so a paged host address is not mistaken for a peripheral one
   reg page_on;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         page_on <= 1'b0;
      else if (cpu_page_wr)
         page_on <= cpu_page_en;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_cb_one_cycle: assert property (cb_req && !cb_ack |=> cb_ack)
      else $error("core port b not answered in one cycle");
   a_fetch_free: assert property (pf_req && !pf_ack && !cb_req |=> pf_ack)
      else $error("fetch held back without three other memory users");
   a_acc_order: assert property (
      acc0_req && !acc0_ack && acc0_addr[31:18] == 14'h0400 && acc1_req && !acc1_ack && acc1_addr[31:18] == 14'h0400
      |=> acc0_ack && !acc1_ack) else $error("accelerator channel order broken");
   a_acc_dual: assert property (
      acc0_req && !acc0_ack && acc0_addr[31:28] == 4'h4 && acc1_req && !acc1_ack && acc1_addr[31:28] == 4'h1
      && !host_req |=> acc1_ack) else $error("accelerator channels not served together");
   a_host_no_per: assert property (
      host_req && !host_ack && host_addr[31:28] == 4'h4 && !page_on |=> host_ack && host_err)
      else $error("host reached the peripheral side");
   a_shared_excl: assert property (
      !(host_ack && !host_err && acc0_ack && !acc0_err && acc0_addr[31:28] == 4'h1))
      else $error("shared memory port used twice at once");
   a_per_hold: assert property (per_req && !(per_ack && peripheral_clock) |=> per_req)
      else $error("peripheral request dropped before its answer");
   a_per_rise_tick: assert property ($rose(per_req) |-> $past(peripheral_clock))
      else $error("peripheral request raised off the divided clock");
   a_div_by_two: assert property (peripheral_clock |=> !peripheral_clock ##1 peripheral_clock)
      else $error("peripheral clock is not sys_clk divided by two");

   c_dual: cover property (acc0_req && acc1_ack);
   c_host_err: cover property (host_ack && host_err);
   c_fetch: cover property (pf_ack && !cb_req);
endmodule

bind xb_crossbar xb_crossbar_monitor u_mon (.*);

// [xb_per_model.sv]
// peripheral target model: one storage word, answers after a set number of ticks.
// assumes per_req and its fields hold until per_ack is seen on a tick edge.
`timescale 1ns/1ps
module xb_per_model (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // peripheral bus
   input wire per_req,
   input wire per_we,
   input wire [31:0] per_wdata,
   input wire peripheral_clock,
   input wire [2:0] per_wait,
   output reg per_ack,
   output reg [31:0] per_rdata
);
   reg [2:0] waited;
   reg [31:0] store;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         waited <= 3'h0;
         per_ack <= 1'b0;
         per_rdata <= 32'h0;
         store <= 32'h0;
      end else if (peripheral_clock) begin
         if (per_ack) begin
            per_ack <= 1'b0;
            per_rdata <= ~per_rdata;
         end else if (per_req && waited == per_wait) begin
            per_ack <= 1'b1;
            per_rdata <= store;
            waited <= 3'h0;
            if (per_we)
               store <= per_wdata;
         end else begin
            // read data churns while idle so a stale sample never matches
            waited <= per_req ? waited + 3'h1 : 3'h0;
            per_rdata <= ~per_rdata;
         end
      end
   end
endmodule

// [tb.sv]
// testbench for the crossbar hub: masters driven by hand, peripheral side modelled.
// assumes xb_crossbar, its checker and xb_per_model are compiled first.
`timescale 1ns/1ps
module tb;
   reg sys_clk = 1'b0;
   reg reset_n = 1'b0;
   reg ca_req = 1'b0, ca_we = 1'b0, cb_req = 1'b0, cb_we = 1'b0, pf_req = 1'b0;
   reg acc0_req = 1'b0, acc0_we = 1'b0, acc1_req = 1'b0, acc1_we = 1'b0, host_req = 1'b0, host_we = 1'b0;
   reg [31:0] ca_addr = 32'h0, cb_addr = 32'h0, pf_addr = 32'h0, acc0_addr = 32'h0, acc1_addr = 32'h0;
   reg [31:0] host_addr = 32'h0, acc0_wdata = 32'h0, acc1_wdata = 32'h0, host_wdata = 32'h0;
   reg [63:0] ca_wdata = 64'h0, cb_wdata = 64'h0;
   reg cpu_page_wr = 1'b0, cpu_page_en = 1'b0;
   reg [15:0] cpu_page_base = 16'h0;
   reg [2:0] per_wait = 3'h0;
   wire ca_ack, ca_err, cb_ack, cb_err, pf_ack, acc0_ack, acc0_err, acc1_ack, acc1_err, host_ack, host_err;
   wire [63:0] ca_rdata, cb_rdata;
   wire [255:0] pf_rdata;
   wire [31:0] acc0_rdata, acc1_rdata, host_rdata, per_addr, per_wdata, per_rdata;
   wire per_req, per_we, per_ack, peripheral_clock;
   integer n_fail = 0, comparisons = 0, cycles = 0, i;

   xb_crossbar uut (.*);
   xb_per_model u_per (.*);

   always #12.5 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task chk(input [255:0] seen, input [255:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
         end
      end
   endtask

   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   // the whole run needs under a hundred cycles
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         n_fail = n_fail + 1;
         conclude;
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task core_pair;
      begin
         @(posedge sys_clk);
         {ca_req, ca_we, cb_req, cb_we} <= 4'hf;
         ca_addr <= 32'h1000_0000;
         ca_wdata <= 64'h1111_2222_3333_4444;
         cb_addr <= 32'h1003_fff8;
         cb_wdata <= 64'h5555_6666_7777_8888;
         @(posedge sys_clk);
         #1 chk({ca_ack, cb_ack}, 2'b11);
         @(posedge sys_clk);
         {ca_we, cb_we, pf_req} <= 3'b001;
         ca_addr <= 32'h1003_fff8;
         cb_addr <= 32'h1000_0000;
         pf_addr <= 32'h1000_0000;
         @(posedge sys_clk);
         #1 chk({ca_ack, cb_ack, pf_ack, ca_rdata}, {3'b111, 64'h5555_6666_7777_8888});
         chk({cb_rdata, pf_rdata[63:0]}, {2{64'h1111_2222_3333_4444}});
         @(posedge sys_clk);
         {ca_req, cb_req, pf_req} <= 3'b000;
      end
   endtask

   task four_way;
      begin
         @(posedge sys_clk);
         {ca_req, cb_req, acc0_req, pf_req} <= 4'hf;
         acc0_addr <= 32'h1000_0000;
         @(posedge sys_clk);
         #1 chk({ca_ack, cb_ack, acc0_ack, pf_ack, acc0_rdata}, {4'b1110, 32'h3333_4444});
         @(posedge sys_clk);
         {ca_req, cb_req, acc0_req} <= 3'b000;
         #1 chk(pf_ack, 1'b1);
         @(posedge sys_clk);
         pf_req <= 1'b0;
      end
   endtask

   task shared_prio;
      begin
         @(posedge sys_clk);
         {acc0_req, acc1_req, host_req} <= 3'b111;
         acc1_addr <= 32'h1000_0004;
         host_addr <= 32'h1003_fffc;
         @(posedge sys_clk);
         #1 chk({acc0_ack, acc1_ack, host_ack}, 3'b100);
         @(posedge sys_clk);
         acc0_req <= 1'b0;
         #1 chk({acc0_ack, acc1_ack, host_ack, acc1_rdata}, {3'b010, 32'h1111_2222});
         @(posedge sys_clk);
         acc1_req <= 1'b0;
         #1 chk({acc1_ack, host_ack, host_err, host_rdata}, {3'b010, 32'h5555_6666});
         @(posedge sys_clk);
         host_req <= 1'b0;
      end
   endtask

   task per_path(input [2:0] lat);
      begin
         @(posedge sys_clk);
         per_wait <= lat;
         {acc0_req, acc0_we, ca_req, ca_we, acc1_req} <= 5'b11101;
         acc0_addr <= 32'h4000_0010;
         acc0_wdata <= {29'h1234_5678, lat};
         ca_addr <= 32'h4000_0010;
         @(posedge sys_clk);
         #1 chk({acc1_ack, ca_ack}, 2'b10);
         @(posedge sys_clk);
         acc1_req <= 1'b0;
         #1;
         for (i = 0; i < 40 && acc0_ack !== 1'b1; i = i + 1) begin
            @(posedge sys_clk);
            #1;
         end
         chk({acc0_ack, acc0_err, ca_ack, per_we, per_addr}, {4'b1001, 32'h4000_0010});
         @(posedge sys_clk);
         acc0_req <= 1'b0;
         #1;
         for (i = 0; i < 40 && ca_ack !== 1'b1; i = i + 1) begin
            @(posedge sys_clk);
            #1;
         end
         chk({ca_ack, ca_err, ca_rdata[31:0]}, {2'b10, 29'h1234_5678, lat});
         @(posedge sys_clk);
         ca_req <= 1'b0;
      end
   endtask

   task host_per;
      begin
         @(posedge sys_clk);
         {host_req, cb_req, acc1_req} <= 3'b111;
         host_addr <= 32'h4000_0010;
         cb_addr <= 32'h4000_0010;
         acc1_addr <= 32'h2000_0000;
         @(posedge sys_clk);
         #1 chk({host_ack, host_err, per_req}, 3'b110);
         chk({cb_ack, cb_err, acc1_ack, acc1_err}, 4'hf);
         @(posedge sys_clk);
         {host_req, cb_req, acc1_req} <= 3'b000;
      end
   endtask

   task host_page;
      begin
         @(posedge sys_clk);
         {cpu_page_wr, cpu_page_en} <= 2'b11;
         cpu_page_base <= 16'h1000;
         @(posedge sys_clk);
         {cpu_page_wr, host_req, pf_req} <= 3'b011;
         host_addr <= 32'h7777_0004;
         pf_addr <= 32'h1003_ffe0;
         @(posedge sys_clk);
         #1 chk({host_ack, host_err, pf_ack, host_rdata}, {3'b101, 32'h1111_2222});
         chk(pf_rdata[255:192], 64'h5555_6666_7777_8888);
         @(posedge sys_clk);
         {cpu_page_wr, cpu_page_en, host_req, pf_req} <= 4'b1000;
         @(posedge sys_clk);
         cpu_page_wr <= 1'b0;
      end
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      core_pair;
      four_way;
      shared_prio;
      per_path(3'h0);
      per_path(3'h4);
      host_per;
      host_page;
      conclude;
   end
endmodule
